//--- ttm_defs.svh
/*
 * Constants of the tape transport motion sequencer: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock.
 */
`ifndef TTM_DEFS_SVH
`define TTM_DEFS_SVH

`define TTM_CLK_HZ 10000000
// Times as specified; scaled per ms first so 32-bit math cannot overflow
`define TTM_CLEAR_MS 20
`define TTM_SERVO_MS 100
`define TTM_LOADED_MS 3000
`define TTM_REV_SLOW_MS 300
`define TTM_REV_BRAKE_MS 140
`define TTM_RUN_MS 13
`define TTM_LOAD_PULSE_US 2
`define TTM_MS_CYC(ms) ((ms) * (`TTM_CLK_HZ / 1000))
`define TTM_CLEAR_CYC `TTM_MS_CYC(`TTM_CLEAR_MS)
`define TTM_SERVO_CYC `TTM_MS_CYC(`TTM_SERVO_MS)
`define TTM_LOADED_CYC `TTM_MS_CYC(`TTM_LOADED_MS)
`define TTM_REV_SLOW_CYC `TTM_MS_CYC(`TTM_REV_SLOW_MS)
`define TTM_REV_BRAKE_CYC `TTM_MS_CYC(`TTM_REV_BRAKE_MS)
`define TTM_RUN_CYC `TTM_MS_CYC(`TTM_RUN_MS)
`define TTM_LOAD_PULSE_CYC (((`TTM_LOAD_PULSE_US) * `TTM_CLK_HZ + 999999) / 1000000)

// Register byte offsets
`define TTM_STATUS_OFS 8'h00
`define TTM_CTRL_OFS 8'h04
// Control fields
`define TTM_CTRL_REWIND 0
`define TTM_CTRL_OFFLINE 1
`define TTM_CTRL_STOP 2
`define TTM_CTRL_RST 32'h00000000
// Input sync reset image: active-low inputs rest high
`define TTM_SYNC_RST 14'h0190
`endif

//--- ttm_pkg.sv
/*
 * Types of the tape transport motion sequencer.
 * Assumes nothing beyond the design that uses it.
 */
package ttm_pkg;
    // Gray codes along idle, reverse, fast, brake, forward
    typedef enum logic [2:0] {
        TTM_IDLE = 3'h0,
        TTM_REV_SLOW = 3'h1,
        TTM_REV_FAST = 3'h3,
        TTM_REV_BRAKE = 3'h2,
        TTM_FWD_SEEK = 3'h6
    } ttm_rw_state_e;
endpackage

//--- ttm_motion_sequencer.sv
/*
 * Motion control sequencer of a vacuum-column tape transport: power and
 * supply-low clear, servo fault, loading, forced braking, rewind sequence
 * and unit ready status, with a classic Wishbone register slave.
 * Assumes switch and sensor inputs are level signals from the transport
 * and a 10 MHz clock; all inputs except the Wishbone bus are resynchronised here.
 */
// How it works
// - Power-up gives 20 ms clear, brakes on
// - Supply low gives 20 ms clear pulse
// - Loaded plus failsafe trip sets fault latch
// - Fault holds like clear until switch off or clear
// - Fault or switch off resets relay latch
// - Relay reset: motors off, timers held
// - Load pulse sets relay, vacuum, seal pulse
// - Both vacuums sensed: servo enable after 100ms
// - Tape loaded 3 s after servo enable
// - Forced brake follows inverse of relay latch
// - Brake release only while lower trip set
// - Release back to off re-applies brakes
// - Rewind command sets latch, reverse drive
// - After 300 ms assert high-speed rewind
// - Marker: forward request, 140 ms braking delay
// - Then forward to marker, clear all
// - Aborted rewind stops cleanly, no fault
// - Motion or off-line keeps running asserted
// - Idle and on-line starts settling flag
// - 13 ms later ready if medium online
// - Status to controller only when selected on-line
// - Load position gives microsecond load pulse
// - Forced braking drives high brake current
`include "ttm_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ttm_motion_sequencer #(
    parameter int unsigned CLEAR_CYC = `TTM_CLEAR_CYC,
    parameter int unsigned SERVO_CYC = `TTM_SERVO_CYC,
    parameter int unsigned LOADED_CYC = `TTM_LOADED_CYC,
    parameter int unsigned REV_SLOW_CYC = `TTM_REV_SLOW_CYC,
    parameter int unsigned REV_BRAKE_CYC = `TTM_REV_BRAKE_CYC,
    parameter int unsigned RUN_CYC = `TTM_RUN_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic supply_low,
    input wire logic switch_load_pos,
    input wire logic switch_off_pos,
    input wire logic brake_release_request_n,
    input wire logic lower_failsafe_trip,
    input wire logic lower_vacuum_left,
    input wire logic lower_vacuum_right,
    input wire logic upper_failsafe_trip_n,
    input wire logic rewind_start_cmd_n,
    input wire logic bot_marker,
    input wire logic motion_active,
    input wire logic offline,
    input wire logic medium_online,
    input wire logic unit_selected,
    output logic power_on_clear_n,
    output logic clear_pulse_signal,
    output logic delayed_offline_clear_n,
    output logic servo_fault,
    output logic load_relay_latch,
    output logic vacuum_motor_on,
    output logic motor_power_on,
    output logic reel_seal_pulse,
    output logic reel_servo_enable_n,
    output logic tape_loaded,
    output logic forced_brake_latch,
    output logic reel_brake_high,
    output logic rewind_sequence_latch,
    output logic reverse_drive,
    output logic high_speed_rewind,
    output logic forward_request_n,
    output logic forward_drive,
    output logic normal_brake,
    output logic running,
    output logic settling_flag_n,
    output logic unit_ready_n
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] tick(input logic [31:0] cnt);
        tick = (cnt == 32'h00000000) ? cnt : cnt - 32'h00000001;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    logic [13:0] in_raw;
    logic [13:0] in_meta;
    logic [13:0] in_sync;
    assign in_raw = {unit_selected, medium_online, offline, motion_active, bot_marker,
                     rewind_start_cmd_n, upper_failsafe_trip_n, lower_vacuum_right,
                     lower_vacuum_left, brake_release_request_n, lower_failsafe_trip,
                     switch_off_pos, switch_load_pos, supply_low};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta <= `TTM_SYNC_RST;
            in_sync <= `TTM_SYNC_RST;
        end else begin
            in_meta <= in_raw;
            in_sync <= in_meta;
        end
    end
    wire s_supply_low = in_sync[0];
    wire s_load_pos = in_sync[1];
    wire s_off_pos = in_sync[2];
    wire s_lfs = in_sync[3];
    wire s_brk_rel = !in_sync[4];
    wire s_vac_both = in_sync[5] & in_sync[6];
    wire s_ufs = !in_sync[7];
    wire s_rwd_cmd = !in_sync[8];
    wire s_bot = in_sync[9];
    wire s_motion = in_sync[10];
    wire s_offline = in_sync[11];
    wire s_mol = in_sync[12];
    wire s_sel = in_sync[13];
    // Idle levels of the synced inputs, so no false edge follows reset
    logic [4:0] prev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 5'h00;
        end else begin
            prev <= {s_bot, s_supply_low, s_load_pos, s_brk_rel, load_relay_latch};
        end
    end
    wire bot_rise = s_bot & !prev[4];
    wire supply_rise = s_supply_low & !prev[3];
    wire load_rise = s_load_pos & !prev[2];
    wire brk_rel_fall = !s_brk_rel & prev[1];
    wire relay_fall = !load_relay_latch & prev[0];
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl;
    logic soft_rewind;
    logic soft_stop;
    wire bus_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire hit_status = wb_adr_i == `TTM_STATUS_OFS;
    wire hit_ctrl = wb_adr_i == `TTM_CTRL_OFS;
    wire ctrl_wr = bus_req & wb_we_i & hit_ctrl & wb_sel_i[0];
    wire [31:0] status_word = {16'h0000, running, !unit_ready_n, !settling_flag_n,
                               normal_brake, forward_drive, !forward_request_n,
                               high_speed_rewind, reverse_drive, rewind_sequence_latch,
                               forced_brake_latch, tape_loaded, !reel_servo_enable_n,
                               load_relay_latch, servo_fault, clear_pulse_signal, 1'b0};
    wire [31:0] next_rd = hit_status ? status_word : (hit_ctrl ? ctrl : 32'h00000000);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl <= `TTM_CTRL_RST;
            soft_rewind <= 1'b0;
            soft_stop <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req & !wb_we_i) ? next_rd : 32'h00000000;
            soft_rewind <= ctrl_wr & wb_dat_i[`TTM_CTRL_REWIND];
            soft_stop <= ctrl_wr & wb_dat_i[`TTM_CTRL_STOP];
            if (ctrl_wr) begin
                ctrl[`TTM_CTRL_OFFLINE] <= wb_dat_i[`TTM_CTRL_OFFLINE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear one-shot; restarted by supply low
    logic [31:0] clr_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt <= 32'(CLEAR_CYC);
        end else begin
            clr_cnt <= supply_rise ? 32'(CLEAR_CYC) : tick(clr_cnt);
        end
    end
    wire clear = clr_cnt != 32'h00000000;
    wire offline_any = s_offline | ctrl[`TTM_CTRL_OFFLINE] | clear;
    // load pulse of a few microseconds
    logic [7:0] lp_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_cnt <= 8'h00;
        end else if (load_rise) begin
            lp_cnt <= 8'(`TTM_LOAD_PULSE_CYC);
        end else if (lp_cnt != 8'h00) begin
            lp_cnt <= lp_cnt - 8'h01;
        end
    end
    wire load_pulse = lp_cnt != 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // fault set on failsafe trip, set wins over switch off
    wire fault_trip = tape_loaded & (s_lfs | s_ufs);
    wire next_fault = fault_trip | (servo_fault & !s_off_pos & !clear);
    // fault blocks like the clear pulse
    wire op_block = clear | servo_fault;
    wire next_relay = !op_block & !s_off_pos & (load_relay_latch | load_pulse);
    wire next_brake = next_relay ? 1'b0 :
                      (s_brk_rel & s_lfs) ? 1'b0 :
                      (relay_fall | brk_rel_fall | clear | !s_brk_rel) ? 1'b1 :
                      forced_brake_latch;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            servo_fault <= 1'b0;
            load_relay_latch <= 1'b0;
            forced_brake_latch <= 1'b1;
            reel_seal_pulse <= 1'b0;
        end else begin
            servo_fault <= next_fault;
            load_relay_latch <= next_relay;
            forced_brake_latch <= next_brake;
            // seal pulse while relay is being set
            reel_seal_pulse <= next_relay & load_pulse;
        end
    end

    // servo enable timer, held while relay is reset
    logic [31:0] servo_cnt;
    logic [31:0] loaded_cnt;
    wire servo_en = load_relay_latch & (servo_cnt == 32'h00000000);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            servo_cnt <= 32'(SERVO_CYC);
            loaded_cnt <= 32'(LOADED_CYC);
        end else begin
            servo_cnt <= !load_relay_latch ? 32'(SERVO_CYC) :
                         (s_vac_both | servo_en) ? tick(servo_cnt) : servo_cnt;
            // tape loaded 3 s after enable
            loaded_cnt <= !servo_en ? 32'(LOADED_CYC) : tick(loaded_cnt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rewind sequence
    ttm_pkg::ttm_rw_state_e rw_state;
    ttm_pkg::ttm_rw_state_e next_rw;
    logic [31:0] rw_cnt;
    // accepted only when loaded, idle and off the marker
    wire rw_accept = (s_rwd_cmd | soft_rewind) & tape_loaded & !s_bot & !op_block;
    // abort path returns to idle without a fault
    wire rw_abort = op_block | !load_relay_latch | soft_stop;
    wire rw_done = rw_cnt == 32'h00000000;
    always_comb begin
        next_rw = rw_state;
        if (rw_abort) begin
            next_rw = ttm_pkg::TTM_IDLE;
        end else begin
            unique case (rw_state)
                ttm_pkg::TTM_IDLE: next_rw = rw_accept ? ttm_pkg::TTM_REV_SLOW : rw_state;
                ttm_pkg::TTM_REV_SLOW: next_rw = bot_rise ? ttm_pkg::TTM_REV_BRAKE :
                                       (rw_done ? ttm_pkg::TTM_REV_FAST : rw_state);
                ttm_pkg::TTM_REV_FAST: next_rw = bot_rise ? ttm_pkg::TTM_REV_BRAKE : rw_state;
                ttm_pkg::TTM_REV_BRAKE: next_rw = rw_done ? ttm_pkg::TTM_FWD_SEEK : rw_state;
                ttm_pkg::TTM_FWD_SEEK: next_rw = bot_rise ? ttm_pkg::TTM_IDLE : rw_state;
                default: next_rw = ttm_pkg::TTM_IDLE;
            endcase
        end
    end
    wire enter_slow = next_rw == ttm_pkg::TTM_REV_SLOW && rw_state != ttm_pkg::TTM_REV_SLOW;
    wire enter_brake = next_rw == ttm_pkg::TTM_REV_BRAKE && rw_state != ttm_pkg::TTM_REV_BRAKE;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rw_state <= ttm_pkg::TTM_IDLE;
            rw_cnt <= 32'h00000000;
        end else begin
            rw_state <= next_rw;
            rw_cnt <= enter_slow ? 32'(REV_SLOW_CYC) :
                      enter_brake ? 32'(REV_BRAKE_CYC) : tick(rw_cnt);
        end
    end

    // Rewind drive outputs registered from the next state
    wire n_rev = next_rw == ttm_pkg::TTM_REV_SLOW || next_rw == ttm_pkg::TTM_REV_FAST ||
                 next_rw == ttm_pkg::TTM_REV_BRAKE;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rewind_sequence_latch <= 1'b0;
            reverse_drive <= 1'b0;
            high_speed_rewind <= 1'b0;
            forward_request_n <= 1'b1;
            forward_drive <= 1'b0;
            normal_brake <= 1'b0;
        end else begin
            rewind_sequence_latch <= next_rw != ttm_pkg::TTM_IDLE;
            reverse_drive <= n_rev;
            high_speed_rewind <= next_rw == ttm_pkg::TTM_REV_FAST;
            forward_request_n <= !(next_rw == ttm_pkg::TTM_REV_BRAKE ||
                                   next_rw == ttm_pkg::TTM_FWD_SEEK);
            forward_drive <= next_rw == ttm_pkg::TTM_FWD_SEEK;
            normal_brake <= next_rw == ttm_pkg::TTM_REV_BRAKE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // running one-shot
    logic [31:0] run_cnt;
    wire run_trig = s_motion | rewind_sequence_latch | offline_any;
    wire run_timing = run_cnt != 32'h00000000;
    // status gated by on-line and selected
    wire status_en = !offline_any & s_sel;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt <= 32'(RUN_CYC);
            running <= 1'b1;
            settling_flag_n <= 1'b1;
            unit_ready_n <= 1'b1;
        end else begin
            run_cnt <= run_trig ? 32'(RUN_CYC) : tick(run_cnt);
            running <= run_trig | run_timing;
            settling_flag_n <= !(status_en & !run_trig & run_timing);
            unit_ready_n <= !(status_en & !run_trig & !run_timing & s_mol);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // motors off with relay; high brake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vacuum_motor_on <= 1'b0;
            motor_power_on <= 1'b0;
            reel_servo_enable_n <= 1'b1;
            tape_loaded <= 1'b0;
            reel_brake_high <= 1'b1;
            clear_pulse_signal <= 1'b1;
        end else begin
            vacuum_motor_on <= next_relay;
            motor_power_on <= next_relay;
            reel_servo_enable_n <= !(servo_en & next_relay);
            tape_loaded <= servo_en & next_relay & (loaded_cnt == 32'h00000000);
            reel_brake_high <= next_brake | clear;
            clear_pulse_signal <= clear;
        end
    end
    assign power_on_clear_n = !clear;
    assign delayed_offline_clear_n = !clear;
    ////////////////////////////////////////////////////////////////////////
    supply_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        supply_rise |-> ##2 clear_pulse_signal[*2]) else $error("no clear on supply low");
    fault_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tape_loaded && (s_lfs || s_ufs)) |=> servo_fault) else $error("fault not latched");
    fault_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        servo_fault |=> !load_relay_latch) else $error("fault did not block");
    relay_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load_relay_latch && s_off_pos) |=> !load_relay_latch) else $error("relay held");
    relay_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !load_relay_latch |-> !vacuum_motor_on && reel_servo_enable_n && !tape_loaded)
        else $error("motor on without relay");
    brake_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(load_relay_latch) |-> !forced_brake_latch) else $error("brake kept on");
    brake_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(forced_brake_latch) |-> $past(s_lfs) || load_relay_latch)
        else $error("brake freed under vacuum");
    rewind_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rw_state == ttm_pkg::TTM_IDLE && rw_accept && !rw_abort) |=>
        rewind_sequence_latch && reverse_drive && !high_speed_rewind)
        else $error("rewind not started");
    fast_rewind_a: assert property (@(posedge clk) disable iff (!rst_n)
        high_speed_rewind |-> reverse_drive && forward_request_n && !forward_drive)
        else $error("bad fast rewind drive");
    status_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(status_en) |-> settling_flag_n && unit_ready_n)
        else $error("status driven off-line");
    settle_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(!settling_flag_n && !unit_ready_n)) else $error("settling and ready together");

endmodule // ttm_motion_sequencer

`default_nettype wire

//--- ttm_transport_model.sv
/* Transport model: column vacuum switches and failsafe trips.
 * Assumes vacuum_motor_on from the sequencer and overrun from the bench. */
`timescale 1ns/10ps
`default_nettype none
module ttm_transport_model #(parameter int unsigned VAC_DLY = 4) (
    input wire logic clk,
    input wire logic vacuum_motor_on,
    input wire logic overrun,
    output logic lower_vacuum_left,
    output logic lower_vacuum_right,
    output logic lower_failsafe_trip,
    output logic upper_failsafe_trip_n
);
    int unsigned age = 0;
    always_ff @(posedge clk) begin
        if (!vacuum_motor_on) begin
            age <= 0;
        end else if (age <= VAC_DLY) begin
            age <= age + 1;
        end
    end
    // Right column seals a cycle late
    assign lower_vacuum_left = (age >= VAC_DLY);
    assign lower_vacuum_right = (age > VAC_DLY);
    // Loop falls below lower switch without vacuum
    assign lower_failsafe_trip = !lower_vacuum_left;
    assign upper_failsafe_trip_n = !overrun;
endmodule // ttm_transport_model
`default_nettype wire

//--- ttm_motion_sequencer_tb_top.sv
/* Bench of the motion sequencer: clear, load, registers, rewind, fault.
 * Assumes the design files and the transport model compile first. */
`timescale 1ns/10ps
`default_nettype none
module ttm_motion_sequencer_tb_top;
    localparam int CL = 20, SV = 10, LD = 30, RS = 10, RB = 8, RN = 12;
    logic clk = 1'h0, reset_n = 1'h0, cyc = 1'h0, we = 1'h0, sup = 1'h0, lp = 1'h0;
    logic off = 1'h1, brn = 1'h1, rwn = 1'h1, bot = 1'h0, sel = 1'h1, ovr = 1'h0;
    logic mot = 1'h0, offl = 1'h0, mol = 1'h1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000, q;
    wire logic [31:0] dat_o;
    wire logic ack, vl, vr, lfs, ufs_n;
    wire logic [20:0] o;
    int failures = 0, n_tests = 0, n;
    ttm_motion_sequencer #(.CLEAR_CYC(CL), .SERVO_CYC(SV), .LOADED_CYC(LD), .REV_SLOW_CYC(RS),
        .REV_BRAKE_CYC(RB), .RUN_CYC(RN)) uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .supply_low(sup), .switch_load_pos(lp),
        .switch_off_pos(off), .brake_release_request_n(brn), .lower_failsafe_trip(lfs),
        .lower_vacuum_left(vl), .lower_vacuum_right(vr), .upper_failsafe_trip_n(ufs_n),
        .rewind_start_cmd_n(rwn), .bot_marker(bot), .motion_active(mot), .offline(offl),
        .medium_online(mol), .unit_selected(sel), .power_on_clear_n(o[19]),
        .clear_pulse_signal(o[0]), .delayed_offline_clear_n(o[20]), .servo_fault(o[1]),
        .load_relay_latch(o[2]), .vacuum_motor_on(o[13]), .motor_power_on(o[15]),
        .reel_seal_pulse(o[12]), .reel_servo_enable_n(o[3]), .tape_loaded(o[4]),
        .forced_brake_latch(o[5]), .reel_brake_high(o[17]), .rewind_sequence_latch(o[6]),
        .reverse_drive(o[16]), .high_speed_rewind(o[7]), .forward_request_n(o[8]),
        .forward_drive(o[9]), .normal_brake(o[18]), .running(o[14]),
        .settling_flag_n(o[10]), .unit_ready_n(o[11]));
    ttm_transport_model xport (.clk(clk), .vacuum_motor_on(o[13]), .overrun(ovr),
        .lower_vacuum_left(vl), .lower_vacuum_right(vr), .lower_failsafe_trip(lfs),
        .upper_failsafe_trip_n(ufs_n));
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", w, exp, seen);
        end
    endtask
    // Edges until an output bit settles; n holds the count
    task wt(input int i, input logic v);
        n = 0;
        while (o[i] !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("wait", o[i], v);
    endtask
    // Classic cycle: held until ack, data taken at that edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        q = dat_o;
        chk("ack", ack, 1'h1);
        cyc <= 1'h0;
        @(posedge clk);
    endtask
    task stop_test;
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task t_clear;
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        chk("brake", o[5], 1'h1);
        chk("clear_n", o[19], 1'h0);
        chk("dly clear_n", o[20], 1'h0);
        wt(0, 1'h0);
        chk("clear len", n >= CL && n <= CL + 4, 1'h1);
        sup <= 1'h1;
        wt(0, 1'h1);
        sup <= 1'h0;
        wt(0, 1'h0);
        chk("supply clear", n >= CL - 1 && n <= CL + 1, 1'h1);
    endtask
    task t_load;
        off <= 1'h0;
        lp <= 1'h1;
        wt(2, 1'h1);
        chk("load delay", n >= 1 && n <= 5, 1'h1);
        @(posedge clk);
        chk("seal", o[12], 1'h1);
        chk("vacuum", o[13] & o[15], 1'h1);
        wt(3, 1'h0);
        chk("servo delay", n >= SV + 3 && n <= SV + 9, 1'h1);
        chk("brake off", o[5] | o[4], 1'h0);
        wt(4, 1'h1);
        chk("load time", n >= LD - 1 && n <= LD + 2, 1'h1);
        lp <= 1'h0;
    endtask
    task t_regs;
        wb(1'h0, 8'h00, 32'h00000000);
        chk("status", q & 32'h00009FFE, 32'h00000038);
        wb(1'h0, 8'h40, 32'h00000000);
        chk("unmapped", q, 32'h00000000);
        wb(1'h1, 8'h04, 32'h00000002);
        wb(1'h0, 8'h04, 32'h00000000);
        chk("ctrl", q & 32'h00000007, 32'h00000002);
        chk("offline", {o[14], o[10], o[11]}, 3'h7);
        wb(1'h1, 8'h04, 32'h00000000);
        wt(10, 1'h0);
        chk("settle", n < 6, 1'h1);
        wt(11, 1'h0);
        chk("ready time", n >= RN - 3 && n <= RN + 2, 1'h1);
        chk("settle end", o[10], 1'h1);
        sel <= 1'h0;
        repeat (4) @(posedge clk);
        chk("gated", o[11], 1'h1);
        sel <= 1'h1;
        repeat (4) @(posedge clk);
        chk("ungated", o[11], 1'h0);
        mol <= 1'h0;
        repeat (4) @(posedge clk);
        chk("no medium", o[11], 1'h1);
        mol <= 1'h1;
        offl <= 1'h1;
        repeat (4) @(posedge clk);
        chk("offline pin", {o[14], o[10], o[11]}, 3'h7);
        offl <= 1'h0;
        mot <= 1'h1;
        repeat (4) @(posedge clk);
        chk("motion", {o[14], o[10], o[11]}, 3'h7);
        mot <= 1'h0;
    endtask
    task t_rewind;
        rwn <= 1'h0;
        @(posedge clk);
        rwn <= 1'h1;
        wt(6, 1'h1);
        chk("reverse", o[16], 1'h1);
        wt(7, 1'h1);
        chk("slow time", n >= RS - 1 && n <= RS + 2, 1'h1);
        bot <= 1'h1;
        wt(8, 1'h0);
        @(posedge clk);
        chk("marker", {o[7], o[18]}, 2'h1);
        bot <= 1'h0;
        wt(9, 1'h1);
        chk("brake time", n >= RB - 3 && n <= RB + 1, 1'h1);
        chk("reverse off", o[16], 1'h0);
        bot <= 1'h1;
        wt(6, 1'h0);
        chk("rewind end", {o[8], o[9]}, 2'h2);
        bot <= 1'h0;
        // Marker must clear the synchroniser before a new rewind
        repeat (3) @(posedge clk);
    endtask
    task t_abort;
        wb(1'h1, 8'h04, 32'h00000001);
        wt(6, 1'h1);
        wb(1'h1, 8'h04, 32'h00000004);
        wt(6, 1'h0);
        chk("abort", {o[16], o[1], o[4]}, 3'h1);
    endtask
    task t_fault;
        ovr <= 1'h1;
        wt(1, 1'h1);
        chk("fault", n < 6, 1'h1);
        wt(2, 1'h0);
        ovr <= 1'h0;
        repeat (3) @(posedge clk);
        chk("unload", {o[13], o[15], o[3], o[4]}, 4'h2);
        chk("brakes", {o[5], o[17]}, 2'h3);
        lp <= 1'h1;
        repeat (8) @(posedge clk);
        chk("refused", {o[1], o[2]}, 2'h2);
        lp <= 1'h0;
        off <= 1'h1;
        wt(1, 1'h0);
        brn <= 1'h0;
        wt(5, 1'h0);
        chk("release", n < 6, 1'h1);
        brn <= 1'h1;
        wt(5, 1'h1);
        chk("reapply", n < 6, 1'h1);
    endtask
    initial begin
        t_clear;
        t_load;
        t_regs;
        t_rewind;
        t_abort;
        t_fault;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test;
    end
endmodule // ttm_motion_sequencer_tb_top
`default_nettype wire
